//--- shared/spf_pkg.sv
package spf_pkg;
  // ==========================================
  // Register map
  localparam logic [3:0]  SPF_OFS_FUNC     = 4'h0;
  localparam logic [3:0]  SPF_OFS_DATA     = 4'h4;
  localparam logic [3:0]  SPF_OFS_CHCTL    = 4'h8;
  localparam logic [15:0] SPF_FUNC_RESET   = 16'hA888;
  localparam logic [7:0]  SPF_DATA_RESET   = 8'h00;
  localparam logic [5:0]  SPF_CHCTL_RESET  = 6'h00;
  localparam int          SPF_TE_POS       = 0;
  localparam int          SPF_RE_POS       = 3;
  localparam logic [1:0]  SPF_RESP_OKAY    = 2'b00;
  localparam logic [1:0]  SPF_RESP_SLVERR  = 2'b10;

  // ==========================================
  // Mode field codes
  localparam logic [1:0]  SPF_MD_ALT       = 2'b00;
  localparam logic [1:0]  SPF_MD_OUT       = 2'b01;
  localparam logic [1:0]  SPF_MD_IN_PU     = 2'b10;
  localparam logic [1:0]  SPF_MD_IN_NOPU   = 2'b11;

  // ==========================================
  // Pin carriers
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [2:0] rx_pu;
  } spf_pad_out_s;

  typedef struct packed {
    logic [2:0] txd;
    logic [2:0] te;
    logic [2:0] re;
  } spf_ser_s;
endpackage

//--- rtl/spf_top.sv
// Notes on behaviour
// - 16-bit function register, reset to A888 by power-on reset only.
// - Paired fields take effect only while that channel's enables are clear; single pins always follow theirs.
// - Transmit enable forces the channel's transmit pin to serial output.
// - Receive enable forces the channel's receive pin to input.
// - Bits 15:14: alt, reserved, input pull-up, input no pull-up.
// - Single pins 6,5,3,1: alt, output, input pull-up, input no pull-up.
// - Paired fields: serial both, tx output, rx input pu, rx input no pu.
// - One shared data bit serves both pins of a pair.
// - Paired upper bit set: transmit pin driven only while transmit enabled.
// - Data read gives stored bit in alt/output modes, pin level in input.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
module spf_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire spf_pkg::spf_ser_s    ser_ctl,
  input  wire logic [7:0]           pad_level,
  input  wire logic [2:0]           rx_level,
  output spf_pkg::spf_pad_out_s     pad_drive,
  output logic [2:0]                rx_data
);
  import spf_pkg::*;

  // ==========================================
  // Pin synchronisers
  logic [7:0] pad_s1_r, pad_s2_r;
  logic [2:0] rx_s1_r, rx_s2_r;
  always_ff @(posedge aclk) begin
    pad_s1_r <= pad_level;
    pad_s2_r <= pad_s1_r;
    rx_s1_r  <= rx_level;
    rx_s2_r  <= rx_s1_r;
  end

  // ==========================================
  // Register bus
  logic [15:0] func_r, func_nxt;
  logic [7:0]  data_r, data_nxt;
  logic [5:0]  chctl_r, chctl_nxt;
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [3:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0]  in_mode;
  logic [7:0]  data_rd;

  // Readies registered as well, so every bus output leaves a flip-flop
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        arready_r, arready_nxt;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_arready = arready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  always_comb begin
    logic       aw_ok, w_ok;
    logic [3:0] a;
    logic [31:0] d;
    logic [3:0] s;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    a     = awaddr_r;
    d     = wdata_r;
    s     = wstrb_r;
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r && !s_axi_bready;
    bresp_nxt   = bresp_r;
    func_nxt    = func_r;
    data_nxt    = data_r;
    chctl_nxt   = chctl_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
      a           = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      d          = s_axi_wdata;
      s          = s_axi_wstrb;
    end
    aw_ok = aw_hold_nxt;
    w_ok  = w_hold_nxt;
    if (aw_ok && w_ok) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = SPF_RESP_OKAY;
      unique case (a)
        SPF_OFS_FUNC: begin
          // Byte lanes honoured, upper half reads zero
          if (s[0]) func_nxt[7:0]  = d[7:0];
          if (s[1]) func_nxt[15:8] = d[15:8];
        end
        SPF_OFS_DATA: begin
          if (s[0]) data_nxt = d[7:0];
        end
        SPF_OFS_CHCTL: begin
          if (s[0]) chctl_nxt = d[5:0];
        end
        default: bresp_nxt = SPF_RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt  = !w_hold_nxt && !bvalid_nxt;
  end

  always_comb begin
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = SPF_RESP_OKAY;
      unique case (s_axi_araddr)
        SPF_OFS_FUNC:  rdata_nxt = {16'h0000, func_r};
        SPF_OFS_DATA:  rdata_nxt = {24'h00_0000, data_rd};
        SPF_OFS_CHCTL: rdata_nxt = {26'h000_0000, chctl_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = SPF_RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_r    <= SPF_FUNC_RESET;
      data_r    <= SPF_DATA_RESET;
      chctl_r   <= SPF_CHCTL_RESET;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 4'h0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= SPF_RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= SPF_RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      func_r    <= func_nxt;
      data_r    <= data_nxt;
      chctl_r   <= chctl_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  // ==========================================
  // Pin multiplexer
  // Effective enables: software bits OR'd with live serial channel enables
  logic [2:0]   te_eff, re_eff;
  spf_pad_out_s pad_nxt, pad_r;
  logic [2:0]   rxd_nxt, rxd_r;
  assign te_eff = chctl_r[SPF_TE_POS +: 3] | ser_ctl.te;
  assign re_eff = chctl_r[SPF_RE_POS +: 3] | ser_ctl.re;

  always_comb begin
    logic [1:0] md;
    int unsigned ch;
    md      = 2'b00;
    ch      = 0;
    pad_nxt = '0;
    in_mode = 8'h00;
    rxd_nxt = 3'b111;
    for (int p = 0; p < 8; p++) begin
      md = func_r[2*p +: 2];
      if (p == 0 || p == 2 || p == 4) begin
        // Pair: pin p transmits; its receive pin is a pad of its own
        ch = unsigned'(p / 2);
        if (te_eff[ch] || md[1] || md == SPF_MD_ALT) begin
          // Serial output only while transmitting, else high-Z
          pad_nxt.o[p]  = ser_ctl.txd[ch];
          pad_nxt.oe[p] = te_eff[ch];
        end else begin
          pad_nxt.o[p]  = data_r[p];
          pad_nxt.oe[p] = 1'b1;
        end
        // Receive enable keeps the receive pad a plain serial input
        pad_nxt.rx_pu[ch] = !re_eff[ch] && (md == SPF_MD_IN_PU);
        if (re_eff[ch] || !md[1]) rxd_nxt[ch] = rx_s2_r[ch];
        else in_mode[p] = 1'b1;
      end else begin
        // Reserved code on pin 7 treated as alternate
        unique case (md)
          SPF_MD_ALT: pad_nxt.oe[p] = 1'b0;
          SPF_MD_OUT: begin
            pad_nxt.o[p]  = data_r[p];
            pad_nxt.oe[p] = (p != 7);
          end
          SPF_MD_IN_PU: begin
            pad_nxt.pu[p] = 1'b1;
            in_mode[p]    = 1'b1;
          end
          SPF_MD_IN_NOPU: in_mode[p] = 1'b1;
        endcase
      end
    end
  end

  // Input pins return the synchronised level; pair data bit reads its rx pin
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!in_mode[b]) data_rd[b] = data_r[b];
      else if (b == 0 || b == 2 || b == 4) data_rd[b] = rx_s2_r[b/2];
      else data_rd[b] = pad_s2_r[b];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_r <= '0;
      rxd_r <= 3'b111;
    end else begin
      // Enables override; field reaches pins one cycle later
      pad_r <= pad_nxt;
      rxd_r <= rxd_nxt;
    end
  end
  assign pad_drive = pad_r;
  assign rx_data   = rxd_r;

  // ==========================================
  // Checks
  AST_RESET_VALUE: assert property (@(posedge aclk)
    $rose(aresetn) |-> func_r == SPF_FUNC_RESET)
    else $error("function register not at reset value");
  AST_TX_FORCED: assert property (@(posedge aclk) disable iff (!aresetn)
    te_eff[0] |=> pad_drive.oe[0] && pad_drive.o[0] == $past(ser_ctl.txd[0]))
    else $error("tx pin not carrying serial output");
  AST_RX_INPUT: assert property (@(posedge aclk) disable iff (!aresetn)
    re_eff[0] |=> !pad_drive.rx_pu[0] && rx_data[0] == $past(rx_s2_r[0]))
    else $error("rx pin not routed to serial receive");
  AST_HIGHZ: assert property (@(posedge aclk) disable iff (!aresetn)
    func_r[1] && !te_eff[0] |=> !pad_drive.oe[0])
    else $error("tx pin not high impedance");
  AST_PIN7_NO_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> !pad_drive.oe[7])
    else $error("pin 7 driven");
  AST_PU6: assert property (@(posedge aclk) disable iff (!aresetn)
    func_r[13:12] == SPF_MD_IN_PU |=> pad_drive.pu[6])
    else $error("pin 6 pull-up missing");
  AST_OUT1: assert property (@(posedge aclk) disable iff (!aresetn)
    func_r[3:2] == SPF_MD_OUT |=> pad_drive.oe[1] && pad_drive.o[1] == $past(data_r[1]))
    else $error("pin 1 general output wrong");
  AST_GPO0: assert property (@(posedge aclk) disable iff (!aresetn)
    func_r[1:0] == SPF_MD_OUT && !te_eff[0]
    |=> pad_drive.oe[0] && pad_drive.o[0] == $past(data_r[0]))
    else $error("paired general output wrong");
  AST_PAIR_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    func_r[1] && !re_eff[0] |-> data_rd[0] == rx_s2_r[0])
    else $error("pair data bit not read from receive pin");
  AST_READ_STORED: assert property (@(posedge aclk) disable iff (!aresetn)
    data_rd[3] == (func_r[7] ? pad_s2_r[3] : data_r[3]))
    else $error("pin 3 read value wrong");
endmodule

//--- dv/spf_pin_model.sv
module spf_pin_model (
  input  wire logic                  aclk,
  input  wire spf_pkg::spf_pad_out_s pad_drive,
  input  wire logic [10:0]           ext_en,
  input  wire logic [10:0]           ext_val,
  output logic [7:0]                 pad_level,
  output logic [2:0]                 rx_level
);
  timeunit 1ns;
  timeprecision 1ps;
  import spf_pkg::*;
  logic flt_r = 1'b0;
  // ==========================================
  // Pin resolution
  // Undriven pin wanders, so a lost pull-up shows
  always_ff @(posedge aclk) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_drive.oe[i]) pad_level[i] = pad_drive.o[i];
      else if (ext_en[i]) pad_level[i] = ext_val[i];
      else if (pad_drive.pu[i]) pad_level[i] = 1'b1;
      else pad_level[i] = flt_r;
    end
    // Receive pads are never driven by the block: far side, pull-up or float
    for (int j = 0; j < 3; j++) begin
      if (ext_en[8+j]) rx_level[j] = ext_val[8+j];
      else if (pad_drive.rx_pu[j]) rx_level[j] = 1'b1;
      else rx_level[j] = flt_r;
    end
  end
endmodule

//--- dv/testbench.sv
module testbench import spf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic         aclk = 1'b0;
  logic         aresetn;
  logic [3:0]   awaddr, araddr, wstrb;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [31:0]  wdata, rdata, d;
  logic [1:0]   bresp, rresp;
  spf_ser_s     ser;
  spf_pad_out_s pad_out;
  logic [7:0]   pad_i;
  logic [10:0]  ext_en, ext_val;
  logic [2:0]   rxd, rx_i;
  int           err_count = 0;
  int           n_compared = 0;

  spf_top u_spf_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ser_ctl(ser), .pad_level(pad_i), .rx_level(rx_i),
    .pad_drive(pad_out), .rx_data(rxd));
  spf_pin_model u_spf_pin_model (.aclk(aclk), .pad_drive(pad_out), .ext_en(ext_en),
    .ext_val(ext_val), .pad_level(pad_i), .rx_level(rx_i));

  always #20 aclk = ~aclk;

  // ==========================================
  // Bus and compare helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [3:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rready <= 1'b0;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic st();
    repeat (4) @(posedge aclk);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(SPF_OFS_FUNC, SPF_RESP_OKAY, d);
    chk("func", 32'h0000_a888, d);
    rd(SPF_OFS_CHCTL, SPF_RESP_OKAY, d);
    chk("chctl", 32'h0000_0000, d);
    chk("pu7", 1, pad_out.pu[7]);
    chk("oe7", 0, pad_out.oe[7]);
  endtask

  task automatic t_single();
    wr(SPF_OFS_DATA, 32'h0000_0040, SPF_RESP_OKAY);
    wr(SPF_OFS_FUNC, 32'h0000_d888, SPF_RESP_OKAY);
    @(posedge aclk);
    chk("oe6", 1, pad_out.oe[6]);
    chk("o6", 1, pad_out.o[6]);
    chk("pu7", 0, pad_out.pu[7]);
    ext_en[7] <= 1'b1;
    ext_val[7] <= 1'b1;
    st();
    rd(SPF_OFS_DATA, SPF_RESP_OKAY, d);
    chk("data76", 2'b11, d[7:6]);
    ext_val[7] <= 1'b0;
    st();
    rd(SPF_OFS_DATA, SPF_RESP_OKAY, d);
    chk("data76", 2'b01, d[7:6]);
    for (int c = 1; c < 4; c++) begin
      wr(SPF_OFS_FUNC, {16'h0, 2'b11, c[1:0], 12'h888}, SPF_RESP_OKAY);
      @(posedge aclk);
      chk("oe6", c == 1, pad_out.oe[6]);
      chk("pu6", c == 2, pad_out.pu[6]);
    end
    wr(SPF_OFS_DATA, 32'h0000_0002, SPF_RESP_OKAY);
    wr(SPF_OFS_FUNC, 32'h0000_a884, SPF_RESP_OKAY);
    @(posedge aclk);
    chk("oe1", 1, pad_out.oe[1]);
    chk("o1", 1, pad_out.o[1]);
  endtask

  task automatic t_pair();
    wr(SPF_OFS_DATA, 32'h0000_0001, SPF_RESP_OKAY);
    wr(SPF_OFS_FUNC, 32'h0000_a889, SPF_RESP_OKAY);
    @(posedge aclk);
    chk("oe0", 1, pad_out.oe[0]);
    chk("o0", 1, pad_out.o[0]);
    ser.te[0] <= 1'b1;
    st();
    chk("o0", 0, pad_out.o[0]);
    ser.txd[0] <= 1'b1;
    st();
    chk("o0", 1, pad_out.o[0]);
    ser.te[0] <= 1'b0;
    wr(SPF_OFS_FUNC, 32'h0000_a88a, SPF_RESP_OKAY);
    st();
    chk("oe0", 0, pad_out.oe[0]);
    chk("rxpu0", 1, pad_out.rx_pu[0]);
    ext_en[8] <= 1'b1;
    st();
    rd(SPF_OFS_DATA, SPF_RESP_OKAY, d);
    chk("data0", 0, d[0]);
    ser.te[0] <= 1'b1;
    ser.re[0] <= 1'b1;
    st();
    chk("oe0", 1, pad_out.oe[0]);
    chk("rxpu0", 0, pad_out.rx_pu[0]);
    chk("rxd0", 0, rxd[0]);
    ser.te[0] <= 1'b0;
    ser.re[0] <= 1'b0;
    wr(SPF_OFS_CHCTL, 32'h0000_0001, SPF_RESP_OKAY);
    @(posedge aclk);
    chk("oe0", 1, pad_out.oe[0]);
    chk("o0", 1, pad_out.o[0]);
    rd(SPF_OFS_CHCTL, SPF_RESP_OKAY, d);
    chk("chctl", 32'h0000_0001, d);
  endtask

  task automatic t_err();
    rd(4'hc, SPF_RESP_SLVERR, d);
    chk("rdata", 0, d);
    wr(4'hc, 32'h0000_0005, SPF_RESP_SLVERR);
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    ser = '0;
    ext_en = '0;
    ext_val = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_single();
    t_pair();
    t_err();
    report_and_stop();
  end

  // Whole run needs about 100 cycles
  initial begin
    #50us;
    err_count++;
    report_and_stop();
  end
endmodule
